// ==== core/rss_pkg.sv ====
// Purpose: Shared constants and types of the rail set-point and slew register block
// Assumes: 100 MHz core clock, 8-bit register subaddresses
// Notes:   Offsets, reset values, field positions and cycle counts live here; the read path, assertions and bench also spell some out as literals
package rss_pkg;

  // Register subaddresses
  localparam logic [7:0] ADDR_BB   = 8'h19;
  localparam logic [7:0] ADDR_SLEW = 8'h1A;
  localparam logic [7:0] ADDR_LDO  = 8'h1B;

  // Values after reset
  localparam logic [7:0] BB_RST   = 8'hB2;
  localparam logic [7:0] SLEW_RST = 8'h06;
  localparam logic [7:0] LDO_RST  = 8'h1F;

  // Field positions and widths
  localparam int unsigned GO_BIT   = 7;
  localparam int unsigned BYP_BIT  = 6;
  localparam int unsigned PSE_BIT  = 7;
  localparam int unsigned SP_W     = 6;
  localparam int unsigned SLEW_W   = 3;

  // Code meanings
  localparam logic [5:0] BB_MAX_CODE    = 6'h34;
  localparam logic [2:0] SLEW_IMMEDIATE = 3'h7;
  localparam logic [5:0] CORE_INIT_CODE = 6'h00;

  // Timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned DWELL_MAX_NS  = 160000;
  localparam int unsigned DWELL_MAX_CYC = DWELL_MAX_NS / CLK_PERIOD_NS;
  localparam int unsigned BLANK_MS      = 5;
  localparam int unsigned BLANK_CYC     = BLANK_MS * 1000000 / CLK_PERIOD_NS;

  localparam int unsigned NUM_CORE  = 2;
  localparam int unsigned NUM_BLANK = 2;

  // Host register access request, one cycle wide
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rss_req_s;

  // Read answer
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rss_rsp_s;

  // Per-rail stepper state
  typedef enum logic [1:0] {
    RSS_STEADY = 2'b01,
    RSS_RAMP   = 2'b10
  } rss_step_e;

endpackage

// ==== core/rss_regs.sv ====
// Purpose: Buck-boost set-point, core buck slew/transition control, linear regulator set-point
// Assumes: Host accesses arrive on the core clock from the serial host logic
// Notes:   Index 0 of the core arrays is core_buck_a, index 1 is core_buck_b
//
// Behaviour
// RL1 - Buck-boost set-point in bits 5-0, resets to 32h, codes above 34h reserved.
// RL2 - Host never writes reserved buck-boost codes nor changes them while running.
// RL3 - Slew and trigger controls steer only the two core buck rails.
// RL4 - Host clears pulse-skip on core bucks before lowering unloaded under tight supervision.
// RL5 - Writing 1 to bit 7 ramps both core bucks to stored set-points.
// RL6 - Trigger bit clears itself when the started transition has finished.
// RL7 - Bypass bit 6 set makes each core set-point update ramp without trigger.
// RL8 - Slew field bits 2-0 resets 6h, codes 0-6 give 160 down to 2.5us.
// RL9 - Slew code 7h applies the new set-point at once.
// RL10 - Linear regulator set-point accepts writes only while password unlocked.
// RL11 - Each linear regulator write blanks its voltage monitoring for 5 ms.
// RL12 - Linear regulator set-point in bits 5-0, resets to 1Fh.
// RL13 - Reserved bits read zero and ignore writes.
`timescale 1ns/10ps

module rss_regs #(
  parameter int unsigned DWELL_CYC = rss_pkg::DWELL_MAX_CYC,
  parameter int unsigned BLANK_LEN = rss_pkg::BLANK_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire rss_pkg::rss_req_s      req,
  output rss_pkg::rss_rsp_s           rsp,
  input  wire logic                   pw_unlocked,
  input  wire logic [1:0][5:0]        core_setpoint,
  input  wire logic [1:0]             core_setpoint_wr,
  output logic      [1:0][5:0]        core_vout_code,
  output logic                        core_ramp_busy,
  output logic      [5:0]             bb_vout_code,
  output logic                        bb_pulse_skip_enable,
  output logic      [5:0]             ldo_vout_code,
  output logic                        ldo_monitor_blank,
  output logic                        bb_monitor_blank
);

  localparam int unsigned CNT_W   = $clog2(DWELL_CYC + 1) + 1;
  localparam int unsigned BLANK_W = $clog2(BLANK_LEN + 1) + 1;

  // Register state
  logic       go_q;
  logic       bypass_q;
  logic [2:0] slew_q;
  logic [5:0] ldo_sp_q;
  logic [5:0] bb_sp_q;
  logic       bb_pse_q;
  logic [7:0] rdata_q;
  logic       rvalid_q;

  // Decoded accesses
  logic wr_slew;
  logic wr_ldo;
  logic wr_bb;
  logic go_launch;
  logic all_done;

  logic [CNT_W-1:0] dwell_len;

  logic [1:0]             ch_start;
  logic [1:0]             ch_done;
  logic [1:0][5:0]        cur_q;
  logic [1:0][5:0]        tgt_q;
  logic [1:0][CNT_W-1:0]  cnt_q;
  rss_pkg::rss_step_e     st_q [2];

  logic [1:0]               blank_start;
  logic [1:0][BLANK_W-1:0]  blank_q;
  logic                     init_q;

  assign wr_slew = req.wr && (req.addr == rss_pkg::ADDR_SLEW);
  assign wr_ldo  = req.wr && (req.addr == rss_pkg::ADDR_LDO) && pw_unlocked; // RL10
  assign wr_bb   = req.wr && (req.addr == rss_pkg::ADDR_BB) && pw_unlocked;

  // Only a written 1 launches; a written 0 leaves go alone
  assign go_launch = wr_slew && req.wdata[rss_pkg::GO_BIT]; // RL5

  // Slew and trigger register
  always_ff @(posedge clk) begin
    if (reset) begin
      bypass_q <= rss_pkg::SLEW_RST[rss_pkg::BYP_BIT];
      slew_q   <= rss_pkg::SLEW_RST[rss_pkg::SLEW_W-1:0]; // RL8
    end else if (wr_slew) begin
      bypass_q <= req.wdata[rss_pkg::BYP_BIT]; // RL7
      slew_q   <= req.wdata[rss_pkg::SLEW_W-1:0]; // RL8
    end
  end

  // Trigger bit: a new launch wins over the self-clear
  always_ff @(posedge clk) begin
    if (reset) begin
      go_q <= rss_pkg::SLEW_RST[rss_pkg::GO_BIT];
    end else if (go_launch) begin
      go_q <= 1'b1; // RL5
    end else if (go_q && all_done) begin
      go_q <= 1'b0; // RL6
    end
  end

  // Linear regulator set-point
  always_ff @(posedge clk) begin
    if (reset) begin
      ldo_sp_q <= rss_pkg::LDO_RST[rss_pkg::SP_W-1:0]; // RL12
    end else if (wr_ldo) begin
      ldo_sp_q <= req.wdata[rss_pkg::SP_W-1:0]; // RL12
    end
  end

  // Buck-boost set-point and pulse-skip enable, stored as written
  always_ff @(posedge clk) begin
    if (reset) begin
      bb_sp_q  <= rss_pkg::BB_RST[rss_pkg::SP_W-1:0]; // RL1
      bb_pse_q <= rss_pkg::BB_RST[rss_pkg::PSE_BIT];
    end else if (wr_bb) begin
      bb_sp_q  <= req.wdata[rss_pkg::SP_W-1:0]; // RL1
      bb_pse_q <= req.wdata[rss_pkg::PSE_BIT];
    end
  end

  // Read path, unmapped addresses answer zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q  <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= req.rd;
      if (req.rd) begin
        case (req.addr)
          rss_pkg::ADDR_SLEW: begin
            rdata_q <= {go_q, bypass_q, 3'h0, slew_q}; // RL13
          end
          rss_pkg::ADDR_LDO: begin
            rdata_q <= {2'h0, ldo_sp_q}; // RL13
          end
          rss_pkg::ADDR_BB: begin
            rdata_q <= {bb_pse_q, 1'h0, bb_sp_q};
          end
          default: begin
            rdata_q <= 8'h00;
          end
        endcase
      end
    end
  end

  assign rsp.valid = rvalid_q;
  assign rsp.data  = rdata_q;

  // Dwell per step halves with each slew code
  assign dwell_len = CNT_W'(DWELL_CYC >> slew_q); // RL8

  // First cycle after reset loads the rails from their set-points
  always_ff @(posedge clk) begin
    if (reset) begin
      init_q <= 1'b1;
    end else begin
      init_q <= 1'b0;
    end
  end

  // Core buck steppers; other rails never pass through here
  genvar ch;
  generate
    for (ch = 0; ch < rss_pkg::NUM_CORE; ch++) begin : g_core
      assign ch_start[ch] = go_launch || (bypass_q && core_setpoint_wr[ch]); // RL3 RL7
      assign ch_done[ch]  = (st_q[ch] == rss_pkg::RSS_STEADY) && (cur_q[ch] == tgt_q[ch]);

      always_ff @(posedge clk) begin
        if (reset) begin
          tgt_q[ch] <= rss_pkg::CORE_INIT_CODE;
        end else if (init_q) begin
          tgt_q[ch] <= core_setpoint[ch];
        end else if (ch_start[ch]) begin
          tgt_q[ch] <= core_setpoint[ch]; // RL5
        end
      end

      always_ff @(posedge clk) begin
        if (reset) begin
          st_q[ch]  <= rss_pkg::RSS_STEADY;
          cur_q[ch] <= rss_pkg::CORE_INIT_CODE;
          cnt_q[ch] <= '0;
        end else if (init_q) begin
          st_q[ch]  <= rss_pkg::RSS_STEADY;
          cur_q[ch] <= core_setpoint[ch];
          cnt_q[ch] <= '0;
        end else if (ch_start[ch]) begin
          st_q[ch]  <= rss_pkg::RSS_RAMP;
          cnt_q[ch] <= '0;
        end else begin
          case (st_q[ch])
            rss_pkg::RSS_STEADY: begin
              cnt_q[ch] <= '0;
            end
            rss_pkg::RSS_RAMP: begin
              if (cur_q[ch] == tgt_q[ch]) begin
                st_q[ch]  <= rss_pkg::RSS_STEADY;
                cnt_q[ch] <= '0;
              end else if (slew_q == rss_pkg::SLEW_IMMEDIATE) begin
                cur_q[ch] <= tgt_q[ch]; // RL9
              end else if (cnt_q[ch] >= dwell_len - CNT_W'(1)) begin
                cnt_q[ch] <= '0;
                if (cur_q[ch] < tgt_q[ch]) begin
                  cur_q[ch] <= cur_q[ch] + 6'h01; // RL8
                end else begin
                  cur_q[ch] <= cur_q[ch] - 6'h01; // RL8
                end
              end else begin
                cnt_q[ch] <= cnt_q[ch] + CNT_W'(1);
              end
            end
            default: begin
              st_q[ch]  <= rss_pkg::RSS_STEADY;
              cnt_q[ch] <= '0;
            end
          endcase
        end
      end

      assign core_vout_code[ch] = cur_q[ch];
    end
  endgenerate

  assign all_done       = &ch_done; // RL6
  assign core_ramp_busy = ~all_done;

  // Monitor blanking after accepted set-point writes
  assign blank_start[0] = wr_ldo; // RL11
  assign blank_start[1] = wr_bb;

  genvar bi;
  generate
    for (bi = 0; bi < rss_pkg::NUM_BLANK; bi++) begin : g_blank
      always_ff @(posedge clk) begin
        if (reset) begin
          blank_q[bi] <= '0;
        end else if (blank_start[bi]) begin
          blank_q[bi] <= BLANK_W'(BLANK_LEN); // RL11
        end else if (blank_q[bi] != '0) begin
          blank_q[bi] <= blank_q[bi] - BLANK_W'(1);
        end
      end
    end
  endgenerate

  assign ldo_monitor_blank    = (blank_q[0] != '0); // RL11
  assign bb_monitor_blank     = (blank_q[1] != '0);
  assign ldo_vout_code        = ldo_sp_q;
  assign bb_vout_code         = bb_sp_q;
  assign bb_pulse_skip_enable = bb_pse_q;

endmodule

// ==== tb/rss_regs_assertions.sv ====
// Purpose: Port assertions of rss_regs
// Assumes: One clock, synchronous reset
// Notes:   Bound to every rss_regs instance
`timescale 1ns/10ps
module rss_regs_assertions #(
  parameter int unsigned DWELL_CYC = 64,
  parameter int unsigned BLANK_LEN = 20
) (
  input wire logic              clk,
  input wire logic              reset,
  input wire rss_pkg::rss_req_s req,
  input wire rss_pkg::rss_rsp_s rsp,
  input wire logic              pw_unlocked,
  input wire logic [1:0][5:0]   core_setpoint,
  input wire logic [1:0]        core_setpoint_wr,
  input wire logic [1:0][5:0]   core_vout_code,
  input wire logic              core_ramp_busy,
  input wire logic [5:0]        bb_vout_code,
  input wire logic              bb_pulse_skip_enable,
  input wire logic [5:0]        ldo_vout_code,
  input wire logic              ldo_monitor_blank,
  input wire logic              bb_monitor_blank
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  logic        acc_ldo;
  logic [31:0] blank_cnt_q;
  assign acc_ldo = req.wr && req.addr == rss_pkg::ADDR_LDO && pw_unlocked;
  // Cycles of blanking since the last accepted write
  always_ff @(posedge clk) begin
    if (reset || acc_ldo) blank_cnt_q <= '0;
    else if (ldo_monitor_blank) blank_cnt_q <= blank_cnt_q + 32'h1;
  end
  sequence s_rd(a);
    req.rd && !req.wr && req.addr == a;
  endsequence
  sequence s_ldo_set;
    ldo_monitor_blank && ldo_vout_code == $past(req.wdata[5:0]);
  endsequence
  property p_ldo_write;
    acc_ldo |=> s_ldo_set;
  endproperty
  property p_ldo_locked;
    req.wr && req.addr == rss_pkg::ADDR_LDO && !pw_unlocked |=> $stable(ldo_vout_code);
  endproperty
  property p_bb_locked;
    req.wr && req.addr == rss_pkg::ADDR_BB && !pw_unlocked |=> $stable(bb_vout_code);
  endproperty
  property p_ldo_read;
    s_rd(rss_pkg::ADDR_LDO) |=> rsp.valid && rsp.data == {2'b00, ldo_vout_code};
  endproperty
  property p_bb_read;
    s_rd(rss_pkg::ADDR_BB) |=> rsp.valid
      && rsp.data == {bb_pulse_skip_enable, 1'b0, bb_vout_code};
  endproperty
  property p_slew_read;
    s_rd(rss_pkg::ADDR_SLEW) |=> rsp.valid && rsp.data[5:3] == 3'h0;
  endproperty
  property p_core_hold;
    !core_ramp_busy && !req.wr && core_setpoint_wr == 2'b00 && !$past(reset)
      |=> $stable(core_vout_code);
  endproperty
  property p_blank_min;
    $rose(ldo_monitor_blank) |-> ldo_monitor_blank[*8];
  endproperty
  property p_blank_len;
    $fell(ldo_monitor_blank) |-> blank_cnt_q == BLANK_LEN;
  endproperty
  property p_go_start;
    req.wr && req.addr == rss_pkg::ADDR_SLEW && req.wdata[7] |=> core_ramp_busy;
  endproperty
  property p_bb_blank;
    req.wr && req.addr == rss_pkg::ADDR_BB && pw_unlocked |=> bb_monitor_blank;
  endproperty
  a_ldo_write: assert property (p_ldo_write) else $error("ldo write lost");
  a_ldo_locked: assert property (p_ldo_locked) else $error("ldo locked write");
  a_bb_locked: assert property (p_bb_locked) else $error("bb locked write");
  a_ldo_read: assert property (p_ldo_read) else $error("ldo read bad");
  a_bb_read: assert property (p_bb_read) else $error("bb read bad");
  a_slew_read: assert property (p_slew_read) else $error("slew read bad");
  a_core_hold: assert property (p_core_hold) else $error("core moved");
  a_blank_min: assert property (p_blank_min) else $error("blank short");
  a_blank_len: assert property (p_blank_len) else $error("blank length");
  a_go_start: assert property (p_go_start) else $error("trigger did not start");
  a_bb_blank: assert property (p_bb_blank) else $error("bb blank missing");
endmodule
bind rss_regs rss_regs_assertions #(.DWELL_CYC(DWELL_CYC), .BLANK_LEN(BLANK_LEN)) u_chk (
  .clk(clk), .reset(reset), .req(req), .rsp(rsp), .pw_unlocked(pw_unlocked),
  .core_setpoint(core_setpoint), .core_setpoint_wr(core_setpoint_wr),
  .core_vout_code(core_vout_code), .core_ramp_busy(core_ramp_busy),
  .bb_vout_code(bb_vout_code), .bb_pulse_skip_enable(bb_pulse_skip_enable),
  .ldo_vout_code(ldo_vout_code), .ldo_monitor_blank(ldo_monitor_blank),
  .bb_monitor_blank(bb_monitor_blank));

// ==== tb/rss_regs_tb.sv ====
// Purpose: Self-checking bench of rss_regs
// Assumes: Short dwell and blanking parameters
// Notes:   Inputs change on the falling edge
`timescale 1ns/10ps
module rss_regs_tb;
  localparam int DW = 64;
  localparam int BL = 20;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic pw = 1'b0;
  logic [1:0] spw = 2'b00;
  logic [1:0][5:0] sp = '0;
  logic [1:0][5:0] core;
  logic [1:0][5:0] cur = '0;
  logic busy;
  logic lb;
  logic [7:0] d;
  rss_pkg::rss_req_s req = '0;
  rss_pkg::rss_rsp_s rsp;
  int miscompares = 0;
  int n_compared = 0;
  int n;
  int lo;
  rss_regs #(.DWELL_CYC(DW), .BLANK_LEN(BL)) DUT (
    .clk(clk), .reset(reset), .req(req), .rsp(rsp), .pw_unlocked(pw),
    .core_setpoint(sp), .core_setpoint_wr(spw), .core_vout_code(core),
    .core_ramp_busy(busy), .bb_vout_code(), .bb_pulse_skip_enable(),
    .ldo_vout_code(), .ldo_monitor_blank(lb), .bb_monitor_blank());
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic int f_ramp(input logic [1:0][5:0] a, input logic [1:0][5:0] b, input int s);
    int m;
    int k;
    m = 0;
    for (int i = 0; i < 2; i++) begin
      k = (a[i] > b[i]) ? int'(a[i] - b[i]) : int'(b[i] - a[i]);
      if (k > m) m = k;
    end
    return (s == 7) ? 0 : m * (DW >> s);
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk);
    req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(negedge clk);
    req = '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req = '0;
    chk({7'h00, rsp.valid, rsp.data}, {7'h00, 1'b1, e});
  endtask
  task automatic wait_idle();
    n = 0;
    while (busy !== 1'b0 && n < 5000) begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    miscompares++;
    summarize();
  end
  initial begin
    void'($urandom(32'hFFAA1E95));
    repeat (8) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    rd(rss_pkg::ADDR_SLEW, 8'h06);
    rd(rss_pkg::ADDR_LDO, 8'h1F);
    rd(rss_pkg::ADDR_BB, 8'hB2);
    rd(8'h3C, 8'h00);
    wr(rss_pkg::ADDR_LDO, 8'h05);
    rd(rss_pkg::ADDR_LDO, 8'h1F);
    pw = 1'b1;
    repeat (4) begin
      d = 8'($urandom);
      wr(rss_pkg::ADDR_LDO, d);
      rd(rss_pkg::ADDR_LDO, {2'b00, d[5:0]});
      // Host keeps off reserved buck-boost codes
      d = (8'($urandom) & 8'hC0) | 8'($urandom % 53);
      wr(rss_pkg::ADDR_BB, d);
      rd(rss_pkg::ADDR_BB, d & 8'hBF);
      d = 8'($urandom) & 8'h7F;
      wr(rss_pkg::ADDR_SLEW, d);
      rd(rss_pkg::ADDR_SLEW, d & 8'h47);
    end
    wr(rss_pkg::ADDR_LDO, 8'hC5);
    n = 0;
    while (lb === 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n), 16'(BL));
    // Every slew code, random targets on both rails
    for (int s = 0; s < 8; s++) begin
      // Core pulse-skip lives outside; host has cleared it before lowering
      sp = 12'($urandom);
      lo = f_ramp(cur, sp, s);
      wr(rss_pkg::ADDR_SLEW, 8'h80 | 8'(s));
      wait_idle();
      chk(16'(n >= lo && n <= lo + (DW >> s) + 4), 16'h1);
      chk(16'(core), 16'(sp));
      cur = sp;
      repeat (2) @(negedge clk);
      rd(rss_pkg::ADDR_SLEW, 8'(s));
    end
    wr(rss_pkg::ADDR_SLEW, 8'h47);
    sp = 12'($urandom);
    @(negedge clk);
    spw = 2'b11;
    @(negedge clk);
    spw = 2'b00;
    wait_idle();
    repeat (3) @(negedge clk);
    chk(16'(core), 16'(sp));
    cur = sp;
    wr(rss_pkg::ADDR_SLEW, 8'h07);
    sp = ~sp;
    @(negedge clk);
    spw = 2'b11;
    @(negedge clk);
    spw = 2'b00;
    repeat (10) @(negedge clk);
    chk(16'(core), 16'(cur));
    // Reset in mid-run brings back the values after reset
    reset = 1'b1;
    repeat (2) @(negedge clk);
    reset = 1'b0;
    @(negedge clk);
    rd(rss_pkg::ADDR_LDO, 8'h1F);
    rd(rss_pkg::ADDR_SLEW, 8'h06);
    summarize();
  end
endmodule
